// >>> verilog/mbs_regs.vh
// constants for the memory map and bus stretch block
`ifndef MBS_REGS_VH
`define MBS_REGS_VH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define MBS_IDX_PORT_A_DATA 5'h00
`define MBS_IDX_PORT_A_DIR 5'h02
`define MBS_IDX_EE_PLACE 5'h12
`define MBS_IDX_MAP_STRETCH 5'h13

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define MBS_EE_POS_HI 7
`define MBS_EE_POS_LO 4
`define MBS_EE_ON_BIT 0
`define MBS_EE_PLACE_RST 8'h01
`define MBS_MS_NARROW_BIT 6
`define MBS_MS_RF_HI 5
`define MBS_MS_RF_LO 4
`define MBS_MS_EX_HI 3
`define MBS_MS_EX_LO 2
`define MBS_MS_FLOC_BIT 1
`define MBS_MS_FEN_BIT 0
`define MBS_MS_RST_EXP 8'h0c
`define MBS_MS_RST_SC 8'h0f
`define MBS_PORT_DIR_RST 8'h00
`define MBS_PORT_DATA_RST 8'h00

// -----------------------------------------------------------------
// map sizes and offsets
// -----------------------------------------------------------------
`define MBS_RF_OFS 16'h0200
`define MBS_RF_SIZE 16'h0200
`define MBS_REG_SIZE 16'h0200
`define MBS_RAM_SIZE 16'h0200
`define MBS_EE_OFS 12'he00
`define MBS_EE_SIZE 12'h200
`define MBS_FLASH_LO 2'h1
`define MBS_FLASH_HI 2'h3
`define MBS_BUSEXP_CNT 16'h0010
`define MBS_PA_DATA_OFS 16'h0000
`define MBS_PB_DIR_OFS 16'h0003
`define MBS_PE_DATA_OFS 16'h0008
`define MBS_PE_DIR_OFS 16'h0009

// -----------------------------------------------------------------
// timing: e clock half period
// -----------------------------------------------------------------
`define MBS_EPH_CYC 8'h04

`endif

// >>> verilog/mbs_bridge.v
// memory map decoder, bus stretch and register file of the bridge
// What this block does
// - eeprom window resets to 0e00, 4k relocatable
// - eeprom position bits give address 15:12
// - position bits write once normal, always special
// - eeprom enable gates array reads and writes
// - eeprom enable reads one in single chip
// - flash location picks 4000 or c000 16k quarter
// - flash location resets by mode
// - flash enable maps flash, resets by mode
// - ram, registers, eeprom, debug rom beat flash
// - mapping control write once normal, always special
// - follow region after registers, optional narrow bus
// - follow region stretched zero to three e clocks
// - external space stretch, resets to three
// - stretch codes ignored in single chip, peripheral
// - strobe, direction, a0 encode size and alignment
// - only ram shows strobe high with a0
// - 8 and 16 bit back to back, strobe marks
// - peripheral mode drops first sixteen registers
// - expanded modes move port a, b registers out
// - port e emulation moves port e registers out
// - port a carries address and data high byte, low byte on narrow odd writes
// - port a general purpose in single chip modes
// - precedence debug, registers, ram, eeprom, flash
// - unclaimed addresses external in expanded modes
// - e clock high for external, low internal when stretching
`default_nettype none
`include "mbs_regs.vh"

module mbs_bridge (
	input wire clk_i,
	input wire sys_rst_i,
	// operating mode and neighbouring map controls
	input wire mode_special_i,
	input wire mode_expanded_i,
	input wire mode_wide_i,
	input wire mode_peripheral_i,
	input wire port_e_emulation_i,
	input wire bus_e_clock_stretch_enable_i,
	input wire debug_rom_active_i,
	input wire [15:0] debug_rom_base_i,
	input wire [4:0] reg_base_i,
	input wire [4:0] ram_base_i,
	// avalon-mm register slave
	input wire [4:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	// cpu access request
	input wire cpu_req_i,
	input wire [15:0] cpu_addr_i,
	input wire cpu_we_i,
	input wire cpu_size16_i,
	input wire [15:0] cpu_wdata_i,
	output reg cpu_ack_o,
	output reg [2:0] cpu_target_o,
	output reg [7:0] ext_rdata_hi_o,
	// external bus control
	output reg bus_e_clock_o,
	output reg low_byte_strobe_n_o,
	output reg bus_rw_o,
	output reg bus_a0_o,
	output reg bus_narrow_o,
	// port a pins
	input wire [7:0] port_a_pins_i,
	output reg [7:0] port_a_pins_o,
	output reg [7:0] port_a_pins_oe_o
);

	// target codes on cpu_target_o
	localparam TGT_NONE = 3'h0;
	localparam TGT_DBG = 3'h1;
	localparam TGT_REG = 3'h2;
	localparam TGT_RAM = 3'h3;
	localparam TGT_EE = 3'h4;
	localparam TGT_FLASH = 3'h5;
	localparam TGT_EXT = 3'h6;

	// access sequencer states
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_DATA = 3'h2;
	localparam ST_INT = 3'h3;
	localparam ST_DONE = 3'h4;

	localparam [7:0] EPH_CYC = `MBS_EPH_CYC;

	reg [7:0] ee_place, map_ctl, port_a_data, port_a_direction, ph_cnt;
	reg ee_written, ms_written, init_done, ph_tick;
	reg [2:0] state;
	reg [3:0] ph_left;
	reg [15:0] acc_addr, acc_wdata;
	reg acc_we, acc_narrow, e_free;

	wire single_chip = ~mode_expanded_i & ~mode_peripheral_i;
	wire bus_mode = mode_expanded_i | mode_peripheral_i;
	wire stretch_on = mode_expanded_i & bus_e_clock_stretch_enable_i;
	// eeprom enable forced on in single chip modes
	wire ee_on = ee_place[`MBS_EE_ON_BIT] | single_chip;

	// -----------------------------------------------------------------
	// address decode
	// -----------------------------------------------------------------
	reg [2:0] dec_tgt;
	reg dec_rf, port_hole;
	reg [15:0] reg_ofs, rf_ofs, ram_ofs;
	reg [11:0] ee_ofs;

	// precedence: debug, registers, ram, eeprom, flash, external
	always @* begin
		reg_ofs = cpu_addr_i - {reg_base_i, 11'h000};
		rf_ofs = reg_ofs - `MBS_RF_OFS;
		ram_ofs = cpu_addr_i - {ram_base_i, 11'h000};
		ee_ofs = cpu_addr_i[11:0] - `MBS_EE_OFS;
		dec_rf = bus_mode & (rf_ofs < `MBS_RF_SIZE);
		// port registers leave the internal map in bus modes
		port_hole = (mode_expanded_i & (reg_ofs <= `MBS_PB_DIR_OFS)) |
			(mode_peripheral_i & (reg_ofs < `MBS_BUSEXP_CNT)) |
			(mode_expanded_i & port_e_emulation_i &
			((reg_ofs == `MBS_PE_DATA_OFS) ||
			(reg_ofs == `MBS_PE_DIR_OFS)));
		dec_tgt = bus_mode ? TGT_EXT : TGT_NONE;
		if (debug_rom_active_i &&
			(cpu_addr_i[15:8] == debug_rom_base_i[15:8])) begin
			dec_tgt = TGT_DBG;
		end else if ((reg_ofs < `MBS_REG_SIZE) && !port_hole) begin
			dec_tgt = TGT_REG;
		end else if ((reg_ofs < `MBS_REG_SIZE) && port_hole) begin
			dec_tgt = TGT_EXT;
		end else if (ram_ofs < `MBS_RAM_SIZE) begin
			dec_tgt = TGT_RAM;
		end else if (ee_on &&
			(cpu_addr_i[15:12] ==
			ee_place[`MBS_EE_POS_HI:`MBS_EE_POS_LO]) &&
			(ee_ofs < `MBS_EE_SIZE)) begin
			dec_tgt = TGT_EE;
		end else if (map_ctl[`MBS_MS_FEN_BIT] &&
			(cpu_addr_i[15:14] == (map_ctl[`MBS_MS_FLOC_BIT] ?
			`MBS_FLASH_HI : `MBS_FLASH_LO))) begin
			dec_tgt = TGT_FLASH;
		end
	end

	// stretch count and bus width of the decoded access
	reg [1:0] dec_str;
	reg dec_narrow;
	always @* begin
		dec_str = 2'h0;
		if (stretch_on) begin
			if (dec_rf) begin
				dec_str = {map_ctl[`MBS_MS_RF_HI],
					map_ctl[`MBS_MS_RF_LO]};
			end else begin
				dec_str = {map_ctl[`MBS_MS_EX_HI],
					map_ctl[`MBS_MS_EX_LO]};
			end
		end
		dec_narrow = mode_expanded_i & ~mode_wide_i;
		if (dec_rf && mode_expanded_i && mode_wide_i) begin
			dec_narrow = map_ctl[`MBS_MS_NARROW_BIT];
		end
	end

	// misaligned 16-bit only for ram, others fall back to one byte
	wire dec_size16 = cpu_size16_i &
		(~cpu_addr_i[0] | (dec_tgt == TGT_RAM));
	wire next_strobe_n = dec_size16 ? cpu_addr_i[0] :
		~cpu_addr_i[0];

	// -----------------------------------------------------------------
	// e clock phase divider
	// -----------------------------------------------------------------
	// one-cycle tick per e clock half period
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ph_cnt <= 8'h00;
			ph_tick <= 1'b0;
		end else if (ph_cnt == EPH_CYC - 8'h01) begin
			ph_cnt <= 8'h00;
			ph_tick <= 1'b1;
		end else begin
			ph_cnt <= ph_cnt + 8'h01;
			ph_tick <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// access sequencer
	// -----------------------------------------------------------------
	// external cycles: one e low phase, then e high for 1+2n phases
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			ph_left <= 4'h0;
			acc_addr <= 16'h0000;
			acc_wdata <= 16'h0000;
			acc_we <= 1'b0;
			acc_narrow <= 1'b0;
			e_free <= 1'b0;
			cpu_ack_o <= 1'b0;
			cpu_target_o <= TGT_NONE;
			ext_rdata_hi_o <= 8'h00;
			bus_e_clock_o <= 1'b0;
			low_byte_strobe_n_o <= 1'b1;
			bus_rw_o <= 1'b1;
			bus_a0_o <= 1'b0;
			bus_narrow_o <= 1'b0;
		end else begin
			cpu_ack_o <= 1'b0;
			if (ph_tick) begin
				e_free <= ~e_free;
			end
			case (state)
			ST_IDLE: begin
				if (cpu_req_i && init_done && ph_tick && e_free) begin
					acc_addr <= cpu_addr_i;
					acc_wdata <= cpu_wdata_i;
					acc_we <= cpu_we_i;
					acc_narrow <= dec_narrow;
					cpu_target_o <= dec_tgt;
					low_byte_strobe_n_o <= next_strobe_n;
					bus_rw_o <= ~cpu_we_i;
					bus_a0_o <= cpu_addr_i[0];
					bus_narrow_o <= dec_narrow;
					ph_left <= {1'b0, dec_str, 1'b1};
					bus_e_clock_o <= 1'b0;
					state <= (dec_tgt == TGT_EXT) ? ST_ADDR : ST_INT;
				end else if (!stretch_on && ph_tick) begin
					bus_e_clock_o <= ~e_free;
				end
			end
			ST_ADDR: begin
				if (ph_tick) begin
					bus_e_clock_o <= 1'b1;
					state <= ST_DATA;
				end
			end
			ST_DATA: begin
				if (ph_tick) begin
					if (ph_left == 4'h1) begin
						bus_e_clock_o <= 1'b0;
						ext_rdata_hi_o <= port_a_pins_i;
						cpu_ack_o <= 1'b1;
						state <= ST_DONE;
					end else begin
						ph_left <= ph_left - 4'h1;
					end
				end
			end
			ST_INT: begin
				if (ph_tick) begin
					// e stays low for internal accesses when stretching
					bus_e_clock_o <= stretch_on ? 1'b0 : ~e_free;
					if (!e_free) begin
						cpu_ack_o <= 1'b1;
						state <= ST_DONE;
					end
				end
			end
			ST_DONE: begin
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// port a pin drive
	// -----------------------------------------------------------------
	// address then data high byte in bus modes (low byte on narrow odd writes), gpio otherwise
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			port_a_pins_o <= 8'h00;
			port_a_pins_oe_o <= 8'h00;
		end else if (!bus_mode) begin
			port_a_pins_o <= port_a_data;
			port_a_pins_oe_o <= port_a_direction;
		end else if (state == ST_ADDR) begin
			port_a_pins_o <= acc_addr[15:8];
			port_a_pins_oe_o <= 8'hff;
		end else if (state == ST_DATA && acc_we) begin
			port_a_pins_o <= (acc_narrow && acc_addr[0]) ?
				acc_wdata[7:0] : acc_wdata[15:8];
			port_a_pins_oe_o <= 8'hff;
		end else begin
			port_a_pins_oe_o <= 8'h00;
		end
	end

	// -----------------------------------------------------------------
	// avalon register slave
	// -----------------------------------------------------------------
	wire avs_req = avs_read_i | avs_write_i;
	wire wr_go = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
	wire pa_mapped = ~bus_mode;
	wire ee_wr_ok = mode_special_i | ~ee_written;
	wire ms_wr_ok = mode_special_i | ~ms_written;

	// one wait state, then a one-cycle answer
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else if (avs_req && avs_waitrequest_o && init_done) begin
			avs_waitrequest_o <= 1'b0;
			avs_readdata_o <= 32'h00000000;
			if (avs_address_i == `MBS_IDX_PORT_A_DATA && pa_mapped) begin
				avs_readdata_o[7:0] <= port_a_data;
			end else if (avs_address_i == `MBS_IDX_PORT_A_DIR &&
				pa_mapped) begin
				avs_readdata_o[7:0] <= port_a_direction;
			end else if (avs_address_i == `MBS_IDX_EE_PLACE) begin
				avs_readdata_o[7:0] <= {ee_place[7:1], ee_on};
			end else if (avs_address_i == `MBS_IDX_MAP_STRETCH) begin
				avs_readdata_o[7:0] <= map_ctl;
			end
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	// register writes and mode-dependent reset values
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ee_place <= `MBS_EE_PLACE_RST;
			map_ctl <= `MBS_MS_RST_EXP;
			port_a_data <= `MBS_PORT_DATA_RST;
			port_a_direction <= `MBS_PORT_DIR_RST;
			ee_written <= 1'b0;
			ms_written <= 1'b0;
			init_done <= 1'b0;
		end else if (!init_done) begin
			init_done <= 1'b1;
			map_ctl <= single_chip ? `MBS_MS_RST_SC :
				`MBS_MS_RST_EXP;
		end else if (wr_go) begin
			if (avs_address_i == `MBS_IDX_PORT_A_DATA && pa_mapped) begin
				port_a_data <= avs_writedata_i[7:0];
			end else if (avs_address_i == `MBS_IDX_PORT_A_DIR &&
				pa_mapped) begin
				port_a_direction <= avs_writedata_i[7:0];
			end else if (avs_address_i == `MBS_IDX_EE_PLACE) begin
				ee_place[`MBS_EE_ON_BIT] <=
					avs_writedata_i[`MBS_EE_ON_BIT];
				if (ee_wr_ok) begin
					ee_written <= 1'b1;
					ee_place[`MBS_EE_POS_HI:`MBS_EE_POS_LO] <=
						avs_writedata_i[`MBS_EE_POS_HI:
						`MBS_EE_POS_LO];
				end
			end else if (avs_address_i == `MBS_IDX_MAP_STRETCH &&
				ms_wr_ok) begin
				ms_written <= 1'b1;
				map_ctl <= {1'b0, avs_writedata_i[6:0]};
			end
		end
	end

endmodule // mbs_bridge
`default_nettype wire

// >>> tb/mbs_ext_mem.sv
// model of external memory on the multiplexed port a bus
`default_nettype none
module mbs_ext_mem (
	input wire logic clk_i,
	input wire logic e_i,
	input wire logic rw_i,
	input wire logic [7:0] pa_o_i,
	input wire logic [7:0] pa_oe_i,
	output logic [7:0] pa_i_o = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// memory side
	// --------
	logic [7:0] adr = 8'h00;
	// latch address in e low, answer reads in e high, else churn
	always @(posedge clk_i) begin
		if (!e_i && pa_oe_i != 8'h00)
			adr <= pa_o_i;
		if (e_i && rw_i)
			pa_i_o <= adr ^ 8'h5a;
		else
			pa_i_o <= ~pa_i_o;
	end
endmodule // mbs_ext_mem
`default_nettype wire

// >>> tb/mbs_bridge_sva.sv
// assertion checker for bridge bus control and decode outputs
`default_nettype none
module mbs_bridge_sva (
	input wire clk_i,
	input wire sys_rst_i,
	input wire mode_expanded_i,
	input wire mode_peripheral_i,
	input wire bus_e_clock_stretch_enable_i,
	input wire avs_waitrequest_o,
	input wire cpu_req_i,
	input wire [15:0] cpu_addr_i,
	input wire cpu_we_i,
	input wire cpu_size16_i,
	input wire cpu_ack_o,
	input wire [2:0] cpu_target_o,
	input wire bus_e_clock_o,
	input wire low_byte_strobe_n_o,
	input wire bus_rw_o,
	input wire bus_a0_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// helpers
	// --------
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [5:0] hi_run;
	wire str_on = mode_expanded_i & bus_e_clock_stretch_enable_i;
	// length of the current e high run
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			hi_run <= 6'h00;
		else
			hi_run <= bus_e_clock_o ? hi_run + 6'h01 : 6'h00;
	end
	// --------
	// properties
	// --------
	property p_ack_pulse;
		cpu_ack_o |-> cpu_req_i ##1 !cpu_ack_o;
	endproperty
	property p_misalign;
		cpu_ack_o && low_byte_strobe_n_o && bus_a0_o |-> cpu_target_o == 3'h3;
	endproperty
	property p_strobe8;
		cpu_ack_o && !cpu_size16_i |-> low_byte_strobe_n_o == !bus_a0_o;
	endproperty
	property p_strobe16;
		cpu_ack_o && cpu_size16_i && !bus_a0_o |-> !low_byte_strobe_n_o;
	endproperty
	property p_rw_a0;
		cpu_ack_o |-> bus_rw_o == !cpu_we_i && bus_a0_o == cpu_addr_i[0];
	endproperty
	property p_e_int;
		cpu_ack_o && str_on && cpu_target_o != 3'h6
			|-> hi_run == 6'h00 && !$past(bus_e_clock_o, 3);
	endproperty
	property p_e_ext;
		cpu_ack_o && str_on && cpu_target_o == 3'h6
			|-> hi_run[1:0] == 2'h0 && hi_run[2] && !bus_e_clock_o;
	endproperty
	property p_sc_int;
		cpu_ack_o && !mode_expanded_i && !mode_peripheral_i
			|-> cpu_target_o != 3'h6;
	endproperty
	property p_wait;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack not a single pulse");
	a_misalign: assert property (p_misalign)
		else $error("misaligned strobe off ram");
	a_strobe8: assert property (p_strobe8)
		else $error("byte strobe encoding");
	a_strobe16: assert property (p_strobe16)
		else $error("word strobe encoding");
	a_rw_a0: assert property (p_rw_a0)
		else $error("direction or a0 wrong");
	a_e_int: assert property (p_e_int)
		else $error("e high on internal access");
	a_e_ext: assert property (p_e_ext)
		else $error("e high length wrong");
	a_sc_int: assert property (p_sc_int)
		else $error("external target in single chip");
	a_wait: assert property (p_wait)
		else $error("waitrequest low too long");
	c_ext: cover property (cpu_ack_o && cpu_target_o == 3'h6);
	c_mis: cover property (cpu_ack_o && low_byte_strobe_n_o && bus_a0_o);
	c_avs: cover property (!avs_waitrequest_o);
endmodule // mbs_bridge_sva
`default_nettype wire

// >>> tb/mbs_bridge_tb.sv
// self-checking testbench of the bridge
`default_nettype none
module mbs_bridge_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// signals and instances
	// --------
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic mode_special_i = 1'b0, mode_expanded_i = 1'b1, mode_wide_i = 1'b1;
	logic mode_peripheral_i = 1'b0, port_e_emulation_i = 1'b1;
	logic bus_e_clock_stretch_enable_i = 1'b1, debug_rom_active_i = 1'b0;
	logic [15:0] debug_rom_base_i = 16'hff00, eh;
	logic [4:0] reg_base_i = 5'h00, ram_base_i = 5'h01, avs_address_i = 5'h00;
	logic avs_read_i = 1'b0, avs_write_i = 1'b0, cpu_req_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
	logic [3:0] avs_byteenable_i = 4'h1;
	logic avs_waitrequest_o, cpu_ack_o, cpu_we_i = 1'b0, cpu_size16_i = 1'b0;
	logic [15:0] cpu_addr_i = 16'h0, cpu_wdata_i = 16'h1234;
	logic [2:0] cpu_target_o;
	logic [7:0] ext_rdata_hi_o, port_a_pins_i, port_a_pins_o;
	logic [7:0] port_a_pins_oe_o, mem_a, rv;
	logic bus_e_clock_o, low_byte_strobe_n_o, bus_rw_o, bus_a0_o, bus_narrow_o;
	int errors = 0, checks = 0;
	// pin level from both drivers
	assign port_a_pins_i = (port_a_pins_oe_o & port_a_pins_o)
		| (~port_a_pins_oe_o & mem_a);
	mbs_bridge mbs_bridge_i (.clk_i, .sys_rst_i, .mode_special_i,
		.mode_expanded_i, .mode_wide_i, .mode_peripheral_i,
		.port_e_emulation_i, .bus_e_clock_stretch_enable_i, .debug_rom_active_i,
		.debug_rom_base_i, .reg_base_i, .ram_base_i, .avs_address_i,
		.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
		.avs_readdata_o, .avs_waitrequest_o, .cpu_req_i, .cpu_addr_i,
		.cpu_we_i, .cpu_size16_i, .cpu_wdata_i, .cpu_ack_o, .cpu_target_o,
		.ext_rdata_hi_o, .bus_e_clock_o, .low_byte_strobe_n_o, .bus_rw_o,
		.bus_a0_o, .bus_narrow_o, .port_a_pins_i, .port_a_pins_o,
		.port_a_pins_oe_o);
	mbs_ext_mem mbs_ext_mem_i (.clk_i, .e_i(bus_e_clock_o), .rw_i(bus_rw_o),
		.pa_o_i(port_a_pins_o), .pa_oe_i(port_a_pins_oe_o), .pa_i_o(mem_a));
	initial forever #5 clk_i = ~clk_i;
	// --------
	// tasks
	// --------
	task automatic chk(input logic [15:0] got, exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic rst(input logic s, e);
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		mode_special_i <= s;
		mode_expanded_i <= e;
		mode_wide_i <= e;
		port_e_emulation_i <= e;
		bus_e_clock_stretch_enable_i <= e;
		ram_base_i <= e ? 5'h01 : 5'h02;
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, d};
		avs_write_i <= w;
		avs_read_i <= !w;
		// hold the request until waitrequest is seen low
		do
			@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0);
		rv = avs_readdata_o[7:0];
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk({8'h00, rv}, {8'h00, e});
	endtask
	task automatic cpu(input logic [15:0] a, input logic w, s,
		input logic [2:0] t);
		@(posedge clk_i);
		cpu_addr_i <= a;
		cpu_we_i <= w;
		cpu_size16_i <= s;
		cpu_req_i <= 1'b1;
		eh = 16'h0;
		@(posedge clk_i);
		while (cpu_ack_o !== 1'b1) begin
			eh = bus_e_clock_o === 1'b1 ? eh + 16'h1 : 16'h0;
			@(posedge clk_i);
		end
		cpu_req_i <= 1'b0;
		chk({13'h0, cpu_target_o}, {13'h0, t});
	endtask
	// --------
	// scenarios
	// --------
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		print_verdict();
	end
	initial begin
		rst(1'b0, 1'b1);
		rd(5'h13, 8'h0c);
		rd(5'h12, 8'h01);
		rd(5'h00, 8'h00);
		rd(5'h05, 8'h00);
		cpu(16'h2000, 1'b0, 1'b0, 3'h6);
		chk(eh, 16'd28);
		chk({8'h0, ext_rdata_hi_o}, 16'h007a);
		cpu(16'h4000, 1'b0, 1'b0, 3'h6);
		cpu(16'h0e00, 1'b0, 1'b0, 3'h4);
		chk(eh, 16'd0);
		cpu(16'h0000, 1'b1, 1'b0, 3'h6);
		cpu(16'h0008, 1'b0, 1'b0, 3'h6);
		bus(1'b1, 5'h13, 8'h61);
		bus(1'b1, 5'h13, 8'h0c);
		rd(5'h13, 8'h61);
		cpu(16'h2000, 1'b1, 1'b0, 3'h6);
		chk(eh, 16'd4);
		cpu(16'h0300, 1'b0, 1'b1, 3'h6);
		chk(eh, 16'd20);
		chk({15'h0, bus_narrow_o}, 16'h0001);
		cpu(16'h4000, 1'b0, 1'b0, 3'h5);
		chk({15'h0, bus_narrow_o}, 16'h0000);
		cpu(16'h0801, 1'b0, 1'b1, 3'h3);
		chk({14'h0, low_byte_strobe_n_o, bus_a0_o}, 16'h0003);
		cpu(16'h2001, 1'b1, 1'b1, 3'h6);
		chk({14'h0, low_byte_strobe_n_o, bus_a0_o}, 16'h0001);
		bus(1'b1, 5'h12, 8'h21);
		bus(1'b1, 5'h12, 8'h31);
		rd(5'h12, 8'h21);
		cpu(16'h2e00, 1'b0, 1'b0, 3'h4);
		bus(1'b1, 5'h12, 8'h30);
		rd(5'h12, 8'h20);
		cpu(16'h2e00, 1'b0, 1'b0, 3'h6);
		rst(1'b1, 1'b0);
		rd(5'h13, 8'h0f);
		debug_rom_active_i <= 1'b1;
		cpu(16'hff10, 1'b0, 1'b0, 3'h1);
		bus(1'b1, 5'h12, 8'hc0);
		rd(5'h12, 8'hc1);
		cpu(16'hce00, 1'b0, 1'b0, 3'h4);
		bus(1'b1, 5'h12, 8'h50);
		rd(5'h12, 8'h51);
		cpu(16'hce00, 1'b0, 1'b0, 3'h5);
		bus(1'b1, 5'h13, 8'h0d);
		bus(1'b1, 5'h13, 8'h0c);
		rd(5'h13, 8'h0c);
		cpu(16'hc000, 1'b0, 1'b0, 3'h0);
		bus(1'b1, 5'h00, 8'ha5);
		bus(1'b1, 5'h02, 8'hff);
		rd(5'h00, 8'ha5);
		chk({port_a_pins_oe_o, port_a_pins_o}, 16'hffa5);
		// peripheral mode: first sixteen registers go external
		mode_peripheral_i <= 1'b1;
		rst(1'b1, 1'b0);
		cpu(16'h000c, 1'b0, 1'b0, 3'h6);
		cpu(16'h0010, 1'b0, 1'b0, 3'h2);
		print_verdict();
	end
endmodule // mbs_bridge_tb
bind mbs_bridge mbs_bridge_sva mbs_bridge_sva_i (.clk_i, .sys_rst_i,
	.mode_expanded_i, .mode_peripheral_i, .bus_e_clock_stretch_enable_i,
	.avs_waitrequest_o, .cpu_req_i, .cpu_addr_i, .cpu_we_i, .cpu_size16_i,
	.cpu_ack_o, .cpu_target_o, .bus_e_clock_o, .low_byte_strobe_n_o,
	.bus_rw_o, .bus_a0_o);
`default_nettype wire
